// ==== hw/log_mem.sv ====
// Purpose: non-volatile log storage, entries then per-memory counters
// Assumes: read data valid one cycle after the address
// Notes: contents are not cleared by reset
`default_nettype none
module log_mem #(
    parameter int unsigned DEPTH = 756,
    parameter int unsigned AW = 10
)(
    input wire logic mclk,
    log_mem_if.mem bus
);
    // blank storage reads as zero, which fails its checksum
    logic [31:0] arr [DEPTH] = '{default: 32'h0};

    always_ff @(posedge mclk) begin
        if (bus.we) begin
            arr[bus.waddr] <= bus.wdata;
        end
        bus.rdata <= arr[bus.raddr];
    end
endmodule
`default_nettype wire

// ==== hw/log_mem_if.sv ====
// Purpose: carrier between the logger and its storage array
// Assumes: one write and one registered read port
// Notes: none
`default_nettype none
interface log_mem_if #(parameter int unsigned AW = 10);
    logic we;
    logic [AW-1:0] waddr, raddr;
    logic [31:0] wdata, rdata;
    modport ctl(output we, waddr, wdata, raddr, input rdata);
    modport mem(input we, waddr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

// ==== hw/usage_datalogger.sv ====
// Purpose: in-situ usage logger with AXI4-Lite register access
// Assumes: state inputs come from logic on mclk; power_on is an external pin
// Notes: storage is log_mem
// Function
// - sample once per programmable interval of 4 s up to 60 minutes
// - write samples into non-volatile storage surviving power cycles
// - enabling logging starts collection only at the next power-up
// - sample battery, volume, memory, environment, ambient, on-time, streaming
// - fill circular buffer in order with battery, volume, memory, environment, ambient
// - each interval increment the active memory counter (memories 0 to 5 only), giving powered-on time
// - 750 entries and 6 counters, all checksum protected
// - append entry when memory, volume or battery state changes
// - optional entry on ambient change above threshold, or none at all
// - software can read back entries and counters
`include "usage_datalogger_consts.svh"
`default_nettype none
module usage_datalogger
    import usage_datalogger_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = `CLK_HZ * `SEC_S
)(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic power_on,
    input wire logic [3:0] battery_level,
    input wire logic [5:0] volume_setting,
    input wire logic [2:0] program_memory,
    input wire logic [2:0] environment,
    input wire logic [7:0] ambient_level,
    input wire logic streaming_active,
    output logic log_active
);
    localparam logic [11:0] IVAL_MIN = 12'(`IVAL_MIN_S);
    localparam logic [11:0] IVAL_MAX = 12'(`IVAL_MAX_MIN * `SEC_PER_MIN);
    localparam logic [9:0] LAST_ENTRY = 10'(`N_ENTRIES - 1);
    localparam logic [9:0] LAST_ADDR = 10'(`N_ENTRIES + `N_COUNTERS - 1);

    dl_state_t s, n;
    log_mem_if #(.AW(10)) mif();
    logic pwr_rise, sec_tick, ival_hit, chg_ev, amb_evt;
    logic [7:0] amb_diff;
    logic [31:0] wval;
    logic [24:0] cnt_val;

    log_mem #(.DEPTH(`N_ENTRIES + `N_COUNTERS), .AW(10)) u_mem (
        .mclk(mclk),
        .bus(mif.mem)
    );

    function automatic logic [31:0] regval(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0;
        case ({a[7:2], 2'b00})
            `A_CTRL: v = {30'h0, s.amb_en, s.en};
            `A_IVAL: v = {20'h0, s.ival_s};
            `A_AMB_TH: v = {24'h0, s.amb_th};
            `A_STATUS: v = {6'h0, s.wr_ptr, 12'h0, s.rd_req, s.rd_err, s.wrapped, s.active};
            `A_RD_IDX: v = {22'h0, s.rd_idx};
            `A_RD_DATA: v = s.rd_data;
            default: v = 32'h0;
        endcase
        return v;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return {a[7:2], 2'b00} <= `A_RD_DATA;
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                           input logic [3:0] b);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (b[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        n = s;
        mif.we = 1'b0;
        mif.waddr = s.wr_ptr;
        mif.wdata = 32'h0;
        mif.raddr = s.rd_idx;
        cnt_val = 25'h0;
        wval = wmerge(regval(s.awaddr), s.wdata, s.wstrb);
        // power-on pin synchroniser and edge
        n.pwr_s1 = power_on;
        n.pwr_s2 = s.pwr_s1;
        n.pwr_s3 = s.pwr_s2;
        pwr_rise = s.pwr_s2 & ~s.pwr_s3;
        if (pwr_rise) begin
            n.active = s.en;
        end
        if (!s.en) begin
            n.active = 1'b0;
        end
        // one-second divider and interval count
        sec_tick = s.active && (s.cyc == 24'(SEC_CYCLES - 1));
        n.cyc = (sec_tick || !s.active) ? 24'h0 : s.cyc + 24'h1;
        ival_hit = sec_tick && (s.sec_in_ival >= s.ival_s - 12'h1);
        if (!s.active || ival_hit) begin
            n.sec_in_ival = 12'h0;
        end else if (sec_tick) begin
            n.sec_in_ival = s.sec_in_ival + 12'h1;
        end
        // change detection against the last logged state
        amb_diff = (ambient_level > s.amb_last) ? ambient_level - s.amb_last
                                                : s.amb_last - ambient_level;
        amb_evt = s.amb_en && (amb_diff > s.amb_th);
        chg_ev = s.active && (s.st == ST_IDLE) && !s.ival_pend && !s.chg_pend &&
                 (battery_level != s.bat_last || volume_setting != s.vol_last ||
                  program_memory != s.mem_last || amb_evt);
        unique case (s.st)
            ST_IDLE: begin
                if (s.ival_pend || s.chg_pend) begin
                    n.st = ST_WR_ENTRY;
                    n.cnt_todo = s.ival_pend;
                    n.ival_pend = 1'b0;
                    n.chg_pend = 1'b0;
                    // snapshot of the sampled state
                    n.bat_last = battery_level;
                    n.vol_last = volume_setting;
                    n.mem_last = program_memory;
                    n.env_last = environment;
                    n.amb_last = ambient_level;
                    n.str_last = streaming_active;
                    n.cnt_mem = program_memory;
                end else if (s.rd_req) begin
                    n.st = ST_RD_BUS;
                end
            end
            ST_WR_ENTRY: begin
                mif.we = 1'b1;
                mif.waddr = s.wr_ptr;
                mif.wdata[24:0] = {s.str_last, s.amb_last, s.env_last, s.mem_last,
                                   s.vol_last, s.bat_last};
                mif.wdata[31:`CSUM_LSB] = csum7(mif.wdata[24:0]);
                if (s.wr_ptr == LAST_ENTRY) begin
                    n.wr_ptr = 10'h0;
                    n.wrapped = 1'b1;
                end else begin
                    n.wr_ptr = s.wr_ptr + 10'h1;
                end
                n.st = (s.cnt_todo && s.cnt_mem < 3'(`N_COUNTERS)) ? ST_RD_CNT : ST_IDLE;
            end
            ST_RD_CNT: begin
                mif.raddr = 10'(`N_ENTRIES) + {7'h0, s.cnt_mem};
                n.st = ST_WR_CNT;
            end
            ST_WR_CNT: begin
                // a counter failing its checksum restarts from one
                cnt_val = (mif.rdata[31:`CSUM_LSB] == csum7(mif.rdata[24:0])) ?
                          mif.rdata[24:0] + 25'h1 : 25'h1;
                mif.we = 1'b1;
                mif.waddr = 10'(`N_ENTRIES) + {7'h0, s.cnt_mem};
                mif.wdata = {csum7(cnt_val), cnt_val};
                n.st = ST_IDLE;
            end
            ST_RD_BUS: begin
                mif.raddr = s.rd_idx;
                n.st = ST_RD_CAP;
            end
            ST_RD_CAP: begin
                n.rd_data = mif.rdata;
                n.rd_err = mif.rdata[31:`CSUM_LSB] != csum7(mif.rdata[24:0]);
                n.rd_req = 1'b0;
                n.st = ST_IDLE;
            end
            default: n.st = ST_IDLE;
        endcase
        if (ival_hit) begin
            n.ival_pend = 1'b1;
        end
        if (chg_ev) begin
            n.chg_pend = 1'b1;
        end
        // register bus write side
        if (s.awready && s_axi_awvalid) begin
            n.aw_full = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s.wready && s_axi_wvalid) begin
            n.w_full = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (s.aw_full && s.w_full && !s.bvalid) begin
            n.aw_full = 1'b0;
            n.w_full = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = mapped(s.awaddr) ? `RESP_OKAY : `RESP_SLVERR;
            case ({s.awaddr[7:2], 2'b00})
                `A_CTRL: begin
                    n.en = wval[`CTRL_EN_BIT];
                    n.amb_en = wval[`CTRL_AMB_BIT];
                end
                `A_IVAL: begin
                    if (|wval[31:12] || wval[11:0] > IVAL_MAX) begin
                        n.ival_s = IVAL_MAX;
                    end else if (wval[11:0] < IVAL_MIN) begin
                        n.ival_s = IVAL_MIN;
                    end else begin
                        n.ival_s = wval[11:0];
                    end
                end
                `A_AMB_TH: n.amb_th = wval[7:0];
                `A_RD_IDX: begin
                    n.rd_idx = (|wval[31:10] || wval[9:0] > LAST_ADDR) ? LAST_ADDR : wval[9:0];
                    n.rd_req = 1'b1;
                end
                default: ;
            endcase
        end
        n.awready = ~n.aw_full & ~n.bvalid;
        n.wready = ~n.w_full & ~n.bvalid;
        // register bus read side
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s.arready && s_axi_arvalid) begin
            n.rvalid = 1'b1;
            n.rdata = regval(s_axi_araddr);
            n.rresp = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        n.arready = ~n.rvalid;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s <= '0;
            s.ival_s <= `IVAL_RST;
            s.amb_th <= `AMB_TH_RST;
        end else begin
            s <= n;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign log_active = s.active;

    sequence seq_cnt_upd;
        s.st == ST_RD_CNT ##1 s.st == ST_WR_CNT;
    endsequence
    property p_interval;
        @(posedge mclk) disable iff (!rst_b) ival_hit |=> s.ival_pend || s.st == ST_WR_ENTRY;
    endproperty
    a_interval: assert property (p_interval) else $error("interval sample lost");
    property p_no_early_start;
        @(posedge mclk) disable iff (!rst_b) (!s.active && !pwr_rise) |=> !s.active;
    endproperty
    a_no_early_start: assert property (p_no_early_start) else $error("early start");
    property p_entry_write;
        @(posedge mclk) disable iff (!rst_b) s.st == ST_WR_ENTRY |-> mif.we &&
            mif.waddr == s.wr_ptr && mif.wdata[3:0] == s.bat_last && mif.wdata[9:4] == s.vol_last;
    endproperty
    a_entry_write: assert property (p_entry_write) else $error("bad entry write");
    property p_wrap;
        @(posedge mclk) disable iff (!rst_b) (s.st == ST_WR_ENTRY && s.wr_ptr == LAST_ENTRY)
            |=> s.wr_ptr == 10'h0 && s.wrapped;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap");
    property p_counter;
        @(posedge mclk) disable iff (!rst_b) seq_cnt_upd |-> mif.we &&
            mif.waddr == 10'(`N_ENTRIES) + {7'h0, s.cnt_mem} && mif.wdata[24:0] != 25'h0;
    endproperty
    a_counter: assert property (p_counter) else $error("counter not written");
    property p_change;
        @(posedge mclk) disable iff (!rst_b) (s.active && s.st == ST_IDLE && !s.ival_pend &&
            !s.chg_pend && volume_setting != s.vol_last) |=> s.chg_pend ##1 s.st == ST_WR_ENTRY;
    endproperty
    a_change: assert property (p_change) else $error("change not logged");
    property p_amb_off;
        @(posedge mclk) disable iff (!rst_b) !s.amb_en |-> !amb_evt;
    endproperty
    a_amb_off: assert property (p_amb_off) else $error("ambient event while off");
    property p_range;
        @(posedge mclk) disable iff (!rst_b) mif.we |-> mif.waddr <= LAST_ADDR;
    endproperty
    a_range: assert property (p_range) else $error("write outside storage");
    property p_readback;
        @(posedge mclk) disable iff (!rst_b) s.st == ST_RD_CAP |=> s.rd_data == $past(mif.rdata)
            && s.rd_err == ($past(mif.rdata[31:25]) != csum7($past(mif.rdata[24:0])));
    endproperty
    a_readback: assert property (p_readback) else $error("readback wrong");
    property p_rd_data;
        @(posedge mclk) disable iff (!rst_b) (s.arready && s_axi_arvalid &&
            s_axi_araddr == `A_RD_DATA) |=> s.rvalid && s.rdata == $past(s.rd_data);
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("bus read wrong");
endmodule
`default_nettype wire

// ==== hw/usage_datalogger_consts.svh ====
// Purpose: offsets, field positions, reset values and timing for the usage logger
// Assumes: included by bare name
// Notes: definitions only
`ifndef USAGE_DATALOGGER_CONSTS_SVH
`define USAGE_DATALOGGER_CONSTS_SVH
`define CLK_HZ 10000000
`define SEC_S 1
`define SEC_PER_MIN 60
`define IVAL_MIN_S 4
`define IVAL_MAX_MIN 60
`define N_ENTRIES 750
`define N_COUNTERS 6
`define A_CTRL 8'h00
`define A_IVAL 8'h04
`define A_AMB_TH 8'h08
`define A_STATUS 8'h0c
`define A_RD_IDX 8'h10
`define A_RD_DATA 8'h14
`define CTRL_EN_BIT 0
`define CTRL_AMB_BIT 1
`define CSUM_LSB 25
`define IVAL_RST 12'h03c
`define AMB_TH_RST 8'h08
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== hw/usage_datalogger_pkg.sv ====
// Purpose: types and checksum for the usage logger
// Assumes: nothing
// Notes: entry word = {csum[6:0], data[24:0]}
`default_nettype none
package usage_datalogger_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WR_ENTRY = 3'b001,
        ST_RD_CNT = 3'b010,
        ST_WR_CNT = 3'b011,
        ST_RD_BUS = 3'b100,
        ST_RD_CAP = 3'b101
    } log_state_t;

    typedef struct packed {
        log_state_t st;
        logic en, amb_en, active, ival_pend, chg_pend, cnt_todo, wrapped, rd_req, rd_err;
        logic pwr_s1, pwr_s2, pwr_s3;
        logic [11:0] ival_s, sec_in_ival;
        logic [23:0] cyc;
        logic [7:0] amb_th, amb_last;
        logic [3:0] bat_last;
        logic [5:0] vol_last;
        logic [2:0] mem_last, env_last, cnt_mem;
        logic str_last;
        logic [9:0] wr_ptr, rd_idx;
        logic [31:0] rd_data;
        logic aw_full, w_full;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready, wready, bvalid, arready, rvalid;
        logic [1:0] bresp, rresp;
        logic [31:0] rdata;
    } dl_state_t;

    function automatic logic [6:0] csum7(input logic [24:0] d);
        return d[6:0] ^ d[13:7] ^ d[20:14] ^ {3'h0, d[24:21]} ^ 7'h5a;
    endfunction
endpackage
`default_nettype wire

// ==== tb/host_model.sv ====
// Purpose: host fitting software acting as AXI4-Lite master
// Assumes: one write and one read under way at a time
// Notes: tasks are called from tb
`default_nettype none
module host_model(
    input wire logic mclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        @(posedge mclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    // single register read with data and response
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                v = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the usage logger
// Assumes: SEC_CYCLES set to 10
// Notes: random state values from an lfsr
`include "usage_datalogger_consts.svh"
`default_nettype none
`define CHK(g, e) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        errors++; \
        $display("ERROR %0t: got %h exp %h", $time, g, e); \
    end \
end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic power_on = 1'b0;
    logic [3:0] bat = 4'h5;
    logic [5:0] vol = 6'h10;
    logic [2:0] mem = 3'h1;
    logic [2:0] env = 3'h2;
    logic [7:0] amb = 8'h40;
    logic str = 1'b1;
    logic log_active;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d, c, lfsr;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, r;
    logic [9:0] p;
    time t0;
    int errors = 0;
    int check_count = 0;
    always #50 mclk = ~mclk;
    usage_datalogger #(.SEC_CYCLES(10)) i_usage_datalogger(
        .mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .power_on(power_on), .battery_level(bat), .volume_setting(vol),
        .program_memory(mem), .environment(env), .ambient_level(amb),
        .streaming_active(str), .log_active(log_active));
    host_model i_host_model(
        .mclk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] word(input logic [24:0] v);
        return {v[6:0] ^ v[13:7] ^ v[20:14] ^ {3'h0, v[24:21]} ^ 7'h5a, v};
    endfunction
    task automatic fetch(input logic [9:0] idx);
        i_host_model.wr(`A_RD_IDX, {22'h0, idx}, r);
        repeat (20) begin
            i_host_model.rd(`A_STATUS, d, r);
            if (d[3] == 1'b0) break;
        end
        `CHK(d[3:2], 2'b00)
        i_host_model.rd(`A_RD_DATA, d, r);
    endtask
    task automatic step(input logic [5:0] nv, input logic [7:0] na, input logic en,
                        input logic full);
        logic [9:0] q;
        i_host_model.rd(`A_STATUS, d, r);
        p = d[25:16];
        lfsr = nxt(lfsr);
        if (en && nv != vol) begin
            bat <= lfsr[3:0];
            mem <= {1'b0, lfsr[5:4]};
            env <= lfsr[8:6];
            str <= lfsr[9];
        end
        vol <= nv;
        amb <= na;
        repeat (8) @(posedge mclk);
        q = (en && p == 10'd749) ? 10'd0 : p + {9'h0, en};
        if (full) begin
            i_host_model.rd(`A_STATUS, d, r);
            `CHK(d[25:16], q)
            if (en) begin
                fetch(p);
                `CHK(d, word({str, amb, env, mem, vol, bat}))
            end
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge mclk);
        errors++;
        $display("ERROR %0t: watchdog expired", $time);
        summarize();
    end
    initial begin
        lfsr = 32'h3eac;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        i_host_model.rd(`A_CTRL, d, r);
        `CHK(d, 32'h0)
        i_host_model.rd(`A_IVAL, d, r);
        `CHK(d[11:0], `IVAL_RST)
        i_host_model.rd(`A_AMB_TH, d, r);
        `CHK(d[7:0], `AMB_TH_RST)
        i_host_model.wr(8'h18, 32'hffff_ffff, r);
        `CHK(r, `RESP_SLVERR)
        i_host_model.rd(8'h18, d, r);
        `CHK({d, r}, {32'h0, `RESP_SLVERR})
        i_host_model.wr(`A_IVAL, 32'h1, r);
        i_host_model.rd(`A_IVAL, d, r);
        `CHK(d[11:0], 12'h004)
        i_host_model.wr(`A_IVAL, 32'hfff, r);
        i_host_model.rd(`A_IVAL, d, r);
        `CHK(d[11:0], 12'he10)
        i_host_model.wr(`A_RD_IDX, 32'h3ff, r);
        i_host_model.rd(`A_RD_IDX, d, r);
        `CHK(d[9:0], 10'd755)
        i_host_model.rd(`A_STATUS, d, r);
        `CHK(d[3:2], 2'b01)
        $display("registers done");
        i_host_model.wr(`A_CTRL, 32'h1, r);
        repeat (10) @(posedge mclk);
        `CHK(log_active, 1'b0)
        power_on <= 1'b1;
        repeat (6) @(posedge mclk);
        `CHK(log_active, 1'b1)
        $display("power-up done");
        i_host_model.wr(`A_IVAL, 32'h4, r);
        repeat (60) @(posedge mclk);
        t0 = $time;
        fetch(10'd750 + {7'h0, mem});
        c = d;
        `CHK(c, word(c[24:0]))
        i_host_model.rd(`A_STATUS, d, r);
        p = d[25:16];
        while ($time < t0 + 4000) @(posedge mclk);
        fetch(10'd750 + {7'h0, mem});
        `CHK(d, word(c[24:0] + 25'h1))
        i_host_model.rd(`A_STATUS, d, r);
        `CHK(d[25:16], (p == 10'd749) ? 10'd0 : p + 10'd1)
        $display("interval done");
        i_host_model.wr(`A_IVAL, 32'he10, r);
        repeat (8) @(posedge mclk);
        repeat (6) step(vol ^ {lfsr[4:0], 1'b1}, amb, 1'b1, 1'b1);
        i_host_model.wr(`A_CTRL, 32'h3, r);
        step(vol, amb + 8'd8, 1'b0, 1'b1);
        step(vol, amb + 8'd1, 1'b1, 1'b1);
        i_host_model.wr(`A_CTRL, 32'h1, r);
        step(vol, amb + 8'd50, 1'b0, 1'b1);
        $display("entries done");
        for (int i = 0; i < 750; i++) step(vol + 6'h1, amb, 1'b1, i == 749);
        i_host_model.rd(`A_STATUS, d, r);
        `CHK(d[1], 1'b1)
        $display("wrap done");
        i_host_model.wr(`A_CTRL, 32'h0, r);
        repeat (2) @(posedge mclk);
        `CHK(log_active, 1'b0)
        step(vol + 6'h1, amb, 1'b0, 1'b1);
        $display("disable done");
        summarize();
    end
endmodule
`default_nettype wire
